// ==== hw/irq_flag_pkg.sv ====
// Package for the interrupt flag unit: register map, field positions, reset values.
// Assumes a single 20 MHz clock and an AHB-Lite register bus with 32-bit data.
package irq_flag_pkg;
	// Register byte addresses
	localparam logic [7:0] pin_flags_addr = 8'h00;
	localparam logic [7:0] event_flags_addr = 8'h04;
	localparam logic [7:0] mask_addr = 8'h08;
	localparam logic [7:0] control_addr = 8'h0c;
	localparam logic [7:0] cpu_addr = 8'h10;
	// Control register fields
	localparam int ctl_pin7_falling_only_bit = 7;
	localparam int ctl_global_enable_bit = 6;
	localparam int ctl_counter_one_16bit_bit = 0;
	localparam int ctl_detector_falling_only_bit = 1;
	localparam int ctl_serial_error_enable_bit = 2;
	// Internal flag positions
	localparam int ev_timer_bit = 0;
	localparam int ev_counter_one_bit = 1;
	localparam int ev_counter_two_bit = 2;
	localparam int ev_detector_bit = 3;
	localparam int ev_serial_bit = 4;
	localparam int ev_caller_bit = 6;
	localparam int ev_transfer_bit = 7;
	// Reset values
	localparam logic [7:0] flags_reset = 8'h00;
	localparam logic [7:0] mask_reset = 8'h00;
	localparam logic [7:0] control_reset = 8'h80;
	localparam logic [15:0] vector_address = 16'h0008;
	localparam logic [7:0] vector_page = 8'h00;
	localparam logic [7:0] event_valid_bits = 8'hdf;
	// Timing counts: edges after reset release before edge history is trusted
	localparam logic [1:0] settle_cycles = 2'h3;
	// Event inputs grouped together
	typedef struct packed {
		logic timer_ovf;
		logic counter_one_ovf8;
		logic counter_one_ovf16;
		logic counter_two_ovf;
		logic energy_detector_output;
		logic tx_empty;
		logic rx_full;
		logic rx_error;
		logic demodulated_fsk_bit;
		logic call_waiting_output;
		logic serial_transfer_done;
		logic tone_digit_valid;
	} event_in_t;
	// CPU context saved on entry
	typedef struct packed {
		logic [7:0] accumulator_reg;
		logic [7:0] status;
		logic [7:0] page;
	} context_t;
endpackage : irq_flag_pkg

// ==== hw/interrupt_flag_unit.sv ====
// Interrupt flag unit: pin and event flags, mask, global enable, context save.
// Assumes AHB-Lite master, asynchronous pins and events, CPU core on clk.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module interrupt_flag_unit
	import irq_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port 7 pins
	input wire logic [7:0] port7_pin,
	// Event sources
	input wire event_in_t events,
	// CPU core
	input wire logic irq_enable_instr,
	input wire logic irq_disable_instr,
	input wire logic return_from_irq_instr,
	input wire logic irq_taken,
	input wire context_t cpu_context,
	output logic irq_request,
	output logic [15:0] vector_pc,
	output logic [7:0] vector_page_out,
	output context_t saved_context
);
	// Register state
	logic [7:0] pin_flags;
	logic [7:0] event_flags;
	logic [7:0] irq_mask_register;
	logic [7:0] control_register;
	context_t context_store;
	// Synchronisers and edge history
	localparam int sync_width = 20;
	logic [sync_width-1:0] sync_a;
	logic [sync_width-1:0] sync_b;
	logic [sync_width-1:0] sync_prev;
	// AHB data-phase capture
	logic wr_pending;
	logic [7:0] wr_addr;

	// Two flip-flops then history; first stage read only by the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_prev <= '0;
		end else begin
			sync_a <= {port7_pin, events};
			sync_b <= sync_a;
			sync_prev <= sync_b;
		end
	end

	// History is trusted only once both stages hold real samples; against the reset
	// zeros an idle-high pin or event would otherwise look like an edge
	logic [1:0] settle_count;
	wire settled = (settle_count == settle_cycles);
	always_ff @(posedge clk) begin
		if (sys_rst)
			settle_count <= 2'h0;
		else if (!settled)
			settle_count <= settle_count + 2'h1;
	end

	// Edge decode on synchronised samples
	wire [7:0] pin_now = sync_b[19:12];
	wire [7:0] pin_old = sync_prev[19:12];
	event_in_t ev_now;
	event_in_t ev_old;
	assign ev_now = event_in_t'(sync_b[11:0]);
	assign ev_old = event_in_t'(sync_prev[11:0]);
	// Per-pin falling-edge detect
	logic [7:0] pin_fall;
	for (genvar g = 0; g < 8; g++) begin : gen_pin_edge
		assign pin_fall[g] = pin_old[g] & ~pin_now[g];
	end
	wire pin7_any = pin_old[7] ^ pin_now[7];
	wire pin7_set = control_register[ctl_pin7_falling_only_bit] ? pin_fall[7] : pin7_any;
	wire [7:0] pin_set = settled ? {pin7_set, pin_fall[6:0]} : 8'h00;

	function automatic logic rise(input logic now, input logic old);
		rise = now & ~old;
	endfunction

	wire ctr1_ovf = control_register[ctl_counter_one_16bit_bit] ?
		rise(ev_now.counter_one_ovf16, ev_old.counter_one_ovf16) :
		rise(ev_now.counter_one_ovf8, ev_old.counter_one_ovf8);
	wire det_fall = ev_old.energy_detector_output & ~ev_now.energy_detector_output;
	wire det_any = ev_old.energy_detector_output ^ ev_now.energy_detector_output;
	wire det_set = control_register[ctl_detector_falling_only_bit] ? det_fall : det_any;
	wire serial_set = rise(ev_now.tx_empty, ev_old.tx_empty)
		| rise(ev_now.rx_full, ev_old.rx_full)
		| (rise(ev_now.rx_error, ev_old.rx_error)
		& control_register[ctl_serial_error_enable_bit]);
	wire caller_set = (ev_old.demodulated_fsk_bit & ~ev_now.demodulated_fsk_bit)
		| (ev_old.call_waiting_output & ~ev_now.call_waiting_output);
	wire transfer_set = rise(ev_now.serial_transfer_done, ev_old.serial_transfer_done)
		| rise(ev_now.tone_digit_valid, ev_old.tone_digit_valid);
	logic [7:0] event_set;
	always_comb begin
		event_set = 8'h00;
		event_set[ev_timer_bit] = rise(ev_now.timer_ovf, ev_old.timer_ovf);
		event_set[ev_counter_one_bit] = ctr1_ovf;
		event_set[ev_counter_two_bit] = rise(ev_now.counter_two_ovf, ev_old.counter_two_ovf);
		event_set[ev_detector_bit] = det_set;
		event_set[ev_serial_bit] = serial_set;
		event_set[ev_caller_bit] = caller_set;
		event_set[ev_transfer_bit] = transfer_set;
		if (!settled) event_set = 8'h00;
	end

	// AHB address phase decode
	wire addr_take = hsel & hready & htrans[1];
	wire wr_pin = wr_pending & (wr_addr == pin_flags_addr);
	wire wr_event = wr_pending & (wr_addr == event_flags_addr);
	wire wr_mask = wr_pending & (wr_addr == mask_addr);
	wire wr_ctl = wr_pending & (wr_addr == control_addr);
	wire [7:0] wdata = hwdata[7:0];

	// Writes may only clear; a set in the same cycle wins
	wire [7:0] next_pin_flags = (pin_flags & ~(wr_pin ? ~wdata : 8'h00)) | pin_set;
	wire [7:0] next_event_flags =
		((event_flags & ~(wr_event ? ~wdata : 8'h00)) | event_set) & event_valid_bits;
	// Mask: software reads and clears only
	wire [7:0] next_mask = wr_mask ? (irq_mask_register & wdata) : irq_mask_register;

	// Global enable handling
	wire ge_clear = irq_disable_instr | irq_taken;
	wire ge_set = irq_enable_instr | return_from_irq_instr;
	logic [7:0] ctl_written;
	always_comb begin
		ctl_written = wr_ctl ? wdata : control_register;
		if (ge_clear)
			ctl_written[ctl_global_enable_bit] = 1'b0;
		else if (ge_set)
			ctl_written[ctl_global_enable_bit] = 1'b1;
	end

	// Flag and control registers; reset clears the flags and mask and loads control with 8'h80
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_flags <= flags_reset;
			event_flags <= flags_reset;
			irq_mask_register <= mask_reset;
			control_register <= control_reset;
		end else begin
			pin_flags <= next_pin_flags;
			event_flags <= next_event_flags;
			irq_mask_register <= next_mask;
			control_register <= ctl_written;
		end
	end

	// Context save on entry, held until the next entry
	always_ff @(posedge clk) begin
		if (sys_rst)
			context_store <= '0;
		else if (irq_taken)
			context_store <= cpu_context;
	end
	assign saved_context = context_store;

	// Request: unmasked event or pending pin flag, gated by global enable
	wire pending = (|(event_flags & irq_mask_register)) | (|pin_flags);
	assign irq_request = pending & control_register[ctl_global_enable_bit];
	assign vector_pc = vector_address;
	assign vector_page_out = vector_page;

	// AHB data phase; zero wait states, OKAY always
	logic [7:0] rd_mux;
	always_comb begin
		unique case (wr_addr)
			pin_flags_addr: rd_mux = pin_flags;
			event_flags_addr: rd_mux = event_flags;
			mask_addr: rd_mux = irq_mask_register;
			control_addr: rd_mux = control_register;
			cpu_addr: rd_mux = {7'h00, irq_request};
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pending <= addr_take & hwrite;
			wr_addr <= addr_take ? haddr[7:0] : 8'hff;
		end
	end
	assign hrdata = {24'h000000, rd_mux};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Checks
	// Per-bit checks on the pin flags
	for (genvar b = 0; b < 8; b++) begin : gen_pin_checks
		// An edge sets the flag whatever the bus does
		pin_set_a: assert property (@(posedge clk) disable iff (sys_rst)
			pin_set[b] |=> pin_flags[b])
			else $error("pin edge lost");
		// A write never raises a pin flag
		no_sw_set_a: assert property (@(posedge clk) disable iff (sys_rst)
			(!pin_flags[b] && !pin_set[b]) |=> !pin_flags[b])
			else $error("pin flag set by write");
		// A zero written with no edge clears the flag
		pin_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
			(wr_pin && !wdata[b] && !pin_set[b]) |=> !pin_flags[b])
			else $error("pin flag kept");
	end
	// Falling-only mode ignores a rising pin 7
	pin7_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		(control_register[7] && $rose(pin_now[7]) && !pin_flags[7]) |=> !pin_flags[7])
		else $error("pin 7 rise in falling mode");
	// Both-edge mode: any change of pin 7 raises flag 7
	pin7_both_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!control_register[ctl_pin7_falling_only_bit] && settled && pin7_any) |=> pin_flags[7])
		else $error("pin 7 edge missed");
	// Set beats a clear in the same cycle
	set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_event && event_set[0]) |=> event_flags[0])
		else $error("set lost to clear");
	// Mask bit 3 can only fall
	mask_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		!irq_mask_register[3] |=> !irq_mask_register[3])
		else $error("mask bit set");
	// Entry drops the global enable
	entry_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_taken |=> !control_register[6])
		else $error("enable kept on entry");
	// Context captured on entry
	save_ctx_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_taken |=> saved_context == $past(cpu_context))
		else $error("context not saved");
	// Context held between entries
	ctx_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!irq_taken |=> $stable(saved_context))
		else $error("context changed");
	// Transfer-done rise raises bit 7
	transfer_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && $rose(ev_now.serial_transfer_done)) |=> event_flags[7])
		else $error("transfer flag missed");
	// Tone digit rise raises bit 7
	tone_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && $rose(ev_now.tone_digit_valid)) |=> event_flags[ev_transfer_bit])
		else $error("tone flag missed");
	// Reserved bit never set
	bit5_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		!event_flags[5])
		else $error("reserved bit set");
	// Timer overflow raises bit 0
	timer_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && $rose(ev_now.timer_ovf)) |=> event_flags[ev_timer_bit])
		else $error("timer flag missed");
	// Counter one in 8-bit mode
	counter_one_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!control_register[0] && settled && $rose(ev_now.counter_one_ovf8)) |=> event_flags[1])
		else $error("counter one flag missed");
	// Counter one in 16-bit mode
	counter_wide_a: assert property (@(posedge clk) disable iff (sys_rst)
		(control_register[0] && settled && $rose(ev_now.counter_one_ovf16)) |=> event_flags[1])
		else $error("wide overflow missed");
	// 8-bit mode ignores the wide overflow
	wide_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!control_register[0] && !event_flags[1] && !$rose(ev_now.counter_one_ovf8))
		|=> !event_flags[1])
		else $error("wrong width overflow");
	// Counter two overflow raises bit 2
	counter_two_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && $rose(ev_now.counter_two_ovf)) |=> event_flags[ev_counter_two_bit])
		else $error("counter two flag missed");
	// Detector falling edge raises bit 3
	detector_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && $fell(ev_now.energy_detector_output)) |=> event_flags[ev_detector_bit])
		else $error("detector flag missed");
	// Falling-only detector mode ignores a rise
	detector_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		(control_register[1] && $rose(ev_now.energy_detector_output) && !event_flags[3])
		|=> !event_flags[3])
		else $error("detector rise in falling mode");
	// Receive error raises bit 4 only when reporting is on
	serial_error_a: assert property (@(posedge clk) disable iff (sys_rst)
		(control_register[2] && settled && $rose(ev_now.rx_error)) |=> event_flags[4])
		else $error("serial error missed");
	serial_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!control_register[2] && !event_flags[4] && !$rose(ev_now.tx_empty)
		&& !$rose(ev_now.rx_full)) |=> !event_flags[4])
		else $error("serial error not gated");
	// Caller data falling edge raises bit 6
	caller_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
		(settled && ($fell(ev_now.demodulated_fsk_bit) || $fell(ev_now.call_waiting_output)))
		|=> event_flags[ev_caller_bit])
		else $error("caller flag missed");
	// Request follows pending flags and global enable
	request_on_a: assert property (@(posedge clk) disable iff (sys_rst)
		(control_register[ctl_global_enable_bit] && (|pin_flags)) |-> irq_request)
		else $error("request missing");
	request_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!(|pin_flags) && ((event_flags & irq_mask_register) == 8'h00)) |-> !irq_request)
		else $error("request without cause");
	// Vector fixed at entry
	vector_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_taken |-> (vector_pc == vector_address && vector_page_out == vector_page))
		else $error("wrong vector");
	// Enable instruction sets the global enable
	enable_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		(irq_enable_instr && !irq_disable_instr && !irq_taken) |=> control_register[6])
		else $error("enable not set");
	// Disable wins over a simultaneous enable
	disable_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		irq_disable_instr |=> !control_register[6])
		else $error("enable kept after disable");
	// Flags leave reset cleared
	reset_clear_a: assert property (@(posedge clk)
		$fell(sys_rst) |-> (pin_flags == 8'h00 && event_flags == 8'h00))
		else $error("flags not cleared by reset");
	// Main scenarios
	cover_pin_c: cover property (@(posedge clk) pin_set[7]);
	cover_req_c: cover property (@(posedge clk) irq_request ##1 irq_taken);
	cover_clash_c: cover property (@(posedge clk) wr_pin && pin_set[0]);
	cover_event_c: cover property (@(posedge clk) event_set[ev_caller_bit]);
	cover_return_c: cover property (@(posedge clk) return_from_irq_instr);
endmodule : interrupt_flag_unit
`default_nettype wire

// ==== verification/cpu_core_model.sv ====
// CPU core stand-in: takes a pending interrupt when allowed and offers its context.
// Assumes clk and the active-high synchronous sys_rst shared with the flag unit.
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model
	import irq_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control from the bench
	input wire logic accept,
	// Interrupt side
	input wire logic irq_request,
	output logic irq_taken,
	output context_t cpu_context
);
	// Fixed context so the saved copy is predictable
	assign cpu_context = '{accumulator_reg: 8'h5a, status: 8'h3c, page: 8'h07};
	// One-cycle entry pulse, never twice in a row: the core needs a cycle to jump
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_taken <= 1'b0;
		end else begin
			irq_taken <= accept & irq_request & ~irq_taken;
		end
	end
endmodule : cpu_core_model
`default_nettype wire

// ==== verification/test_interrupt_flag_unit.sv ====
// Bench for the interrupt flag unit: bus tasks, pin and event stimulus, queued reads.
// Assumes a zero-wait bus slave and a three-edge input sampling delay.
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_flag_unit import irq_flag_pkg::*; ;
	logic clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, rd_phase = 1'b0, accept = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [7:0] port7_pin = 8'hff, r;
	logic [11:0] ev = 12'h08c;
	logic [2:0] instr = 3'h0;
	logic hreadyout, hresp, irq_taken, irq_request;
	logic [15:0] vector_pc;
	logic [7:0] vector_page_out;
	context_t cpu_context, saved_context;
	logic [7:0] exp_q[$];
	int fail_count = 0, total_checks = 0, seed = 36;
	// Expected event flags per field, 8-bit mode then 16-bit mode with error reporting
	logic [7:0] ev_exp [2][12] = '{'{8'h01, 8'h02, 8'h00, 8'h04, 8'h08, 8'h10, 8'h10, 8'h00,
		8'h40, 8'h40, 8'h80, 8'h80}, '{8'h01, 8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10,
		8'h40, 8'h40, 8'h80, 8'h80}};
	interrupt_flag_unit i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port7_pin(port7_pin),
		.events(event_in_t'(ev)), .irq_enable_instr(instr[2]), .irq_disable_instr(instr[1]),
		.return_from_irq_instr(instr[0]), .irq_taken(irq_taken), .cpu_context(cpu_context),
		.irq_request(irq_request), .vector_pc(vector_pc), .vector_page_out(vector_page_out),
		.saved_context(saved_context));
	cpu_core_model i_cpu (.clk(clk), .sys_rst(sys_rst), .accept(accept),
		.irq_request(irq_request), .irq_taken(irq_taken), .cpu_context(cpu_context));
	// Clock at 50 ns
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// One single transfer; a read notes d as the expected low byte
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 16);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rd_phase <= ~w;
		do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 32);
		rd_phase <= 1'b0;
		if (hreadyout !== 1'b1) begin
			fail_count++;
			wrap_up();
		end
	endtask : bus
	// Read data is compared against the oldest note at the data-phase edge
	always @(posedge clk) begin
		if (rd_phase && hreadyout) check(hrdata, {24'h0, exp_q.pop_front()});
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		tick(12);
		sys_rst <= 1'b0;
		bus(0, pin_flags_addr, 8'h00);
		bus(0, event_flags_addr, 8'h00);
		bus(1, mask_addr, 8'hff);
		bus(0, mask_addr, 8'h00);
		bus(0, control_addr, 8'h80);
		bus(1, 8'h14, 8'hff);
		bus(0, 8'h14, 8'h00);
		// Each pin: falling edge sets, one leaves, zero clears, rising is ignored
		for (int i = 0; i < 8; i++) begin
			port7_pin[i] <= 1'b0;
			tick(5);
			bus(0, pin_flags_addr, 8'(1 << i));
			bus(1, pin_flags_addr, 8'hff);
			bus(0, pin_flags_addr, 8'(1 << i));
			bus(1, pin_flags_addr, 8'h00);
			port7_pin[i] <= 1'b1;
			tick(5);
			bus(0, pin_flags_addr, 8'h00);
		end
		// Pin 7 on both edges, then a set landing on a clear
		bus(1, control_addr, 8'h00);
		port7_pin[7] <= 1'b0;
		tick(5);
		bus(1, pin_flags_addr, 8'h00);
		port7_pin[7] <= 1'b1;
		tick(5);
		bus(0, pin_flags_addr, 8'h80);
		port7_pin[5] <= 1'b0;
		bus(1, pin_flags_addr, 8'h00);
		bus(0, pin_flags_addr, 8'h20);
		// Random clear patterns on a full set of flags
		repeat (4) begin
			port7_pin <= 8'hff;
			tick(5);
			bus(1, pin_flags_addr, 8'h00);
			port7_pin <= 8'h00;
			tick(5);
			r = 8'($random(seed));
			bus(1, pin_flags_addr, r);
			bus(0, pin_flags_addr, r);
		end
		bus(1, pin_flags_addr, 8'h00);
		// Every event source in both counter widths
		for (int m = 0; m < 2; m++) begin
			bus(1, control_addr, m ? 8'h87 : 8'h80);
			for (int k = 0; k < 12; k++) begin
				ev[11 - k] <= ~ev[11 - k];
				tick(6);
				ev[11 - k] <= ~ev[11 - k];
				tick(5);
				bus(0, event_flags_addr, ev_exp[m][k]);
				bus(1, event_flags_addr, 8'h00);
			end
		end
		// Falling-only detector: a rising output leaves the flag clear
		ev[7] <= 1'b0;
		tick(5);
		bus(1, event_flags_addr, 8'h00);
		ev[7] <= 1'b1;
		tick(5);
		bus(0, event_flags_addr, 8'h00);
		// Masked event, then a pin request taken and returned from
		ev[11] <= 1'b1;
		tick(6);
		ev[11] <= 1'b0;
		instr <= 3'h4;
		tick(1);
		instr <= 3'h0;
		tick(5);
		bus(0, cpu_addr, 8'h00);
		bus(0, control_addr, 8'hc7);
		port7_pin[0] <= 1'b1;
		tick(5);
		port7_pin[0] <= 1'b0;
		tick(5);
		bus(0, cpu_addr, 8'h01);
		accept <= 1'b1;
		tick(4);
		accept <= 1'b0;
		check({8'h00, saved_context}, 32'h005a3c07);
		check({vector_page_out, vector_pc}, 32'h00000008);
		bus(0, cpu_addr, 8'h00);
		instr <= 3'h1;
		tick(1);
		instr <= 3'h6;
		tick(1);
		instr <= 3'h0;
		bus(0, control_addr, 8'h87);
		wrap_up();
	end
endmodule : test_interrupt_flag_unit
`default_nettype wire
